// File: dasp_pkg.sv
// constants and register map of the digital audio serial port
package dasp_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CONFIG   = 8'h00;
   localparam logic [7:0] OFS_CONTROL  = 8'h04;
   localparam logic [7:0] OFS_TX_LEFT  = 8'h08;
   localparam logic [7:0] OFS_TX_RIGHT = 8'h0C;
   localparam logic [7:0] OFS_RX_LEFT  = 8'h10;
   localparam logic [7:0] OFS_RX_RIGHT = 8'h14;
   localparam logic [7:0] OFS_STATUS   = 8'h18;
   // config word fields
   localparam int CFG_JUSTIFY  = 0;
   localparam int CFG_DELAY    = 1;
   localparam int CFG_POL      = 2;
   localparam int CFG_ATT_EN   = 3;
   localparam int CFG_ATT_LO   = 4;
   localparam int CFG_RES_LO   = 8;
   localparam int CFG_CROP     = 10;
   localparam logic [15:0] CFG_MASK  = 16'h07FF;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   // resolution codes
   localparam logic [1:0] RES_16 = 2'h0;
   localparam logic [1:0] RES_20 = 2'h1;
   localparam logic [1:0] RES_24 = 2'h2;
   // control and status fields
   localparam int CTL_OWN    = 0;
   localparam int CTL_MASTER = 1;
   localparam int CTL_DIV_LO = 8;
   localparam int STS_FRESH  = 0;
   localparam int STS_OVR    = 1;
   // sample widths
   localparam int SAMPLE_W = 16;
   localparam int RAW_W    = 24;
   localparam int ROUND_SH = 8;
   // bit clock half period floor
   localparam int CLK_MHZ         = 200;
   localparam int SCK_HALF_MIN_NS = 80;
   localparam int SCK_HALF_CYC    = (SCK_HALF_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] DIV_RESET = 8'(SCK_HALF_CYC);
endpackage

// File: dasp_xfer_if.sv
// carrier between the register side and the link side
`timescale 1ns/1ps
`default_nettype none
interface dasp_xfer_if;
   logic        rst;     // core reset level
   logic        req;     // shadow handshake toggle
   logic        ack;     // link acknowledge toggle
   logic [15:0] sh_cfg;  // shadow config
   logic [15:0] sh_txl;  // shadow left sample
   logic [15:0] sh_txr;  // shadow right sample
   logic        sh_mst;  // shadow master flag
   logic        rx_tgl;  // new received pair toggle
   logic [23:0] rx_l;    // raw left word
   logic [23:0] rx_r;    // raw right word
   logic        sd_in;   // data pin level
   logic        ws_in;   // word select pin level
   logic        sd_out;  // data to pin
   logic        ws_out;  // word select to pin
   modport core (output rst, req, sh_cfg, sh_txl, sh_txr, sh_mst, sd_in, ws_in,
                 input ack, rx_tgl, rx_l, rx_r, sd_out, ws_out);
   modport serial (input rst, req, sh_cfg, sh_txl, sh_txr, sh_mst, sd_in, ws_in,
                   output ack, rx_tgl, rx_l, rx_r, sd_out, ws_out);
endinterface
`default_nettype wire

// File: dasp_serial.sv
// link-clock serial engine: framing, shifting, word select
`timescale 1ns/1ps
`default_nettype none
module dasp_serial #(
   parameter int HALF_BITS = 32
) (
   input wire logic  link_sck_i,
   dasp_xfer_if.serial x
);
   import dasp_pkg::*;

   typedef struct packed {
      logic        req_s1, req_s2, seen;
      logic [15:0] cfg, txl, txr;
      logic        mst, ws_prev, ws_gen, nbit, rx_tgl;
      logic [5:0]  cnt, last_len;
      logic [23:0] sh, lcap, rcap;
   } dasp_ser_t;

   dasp_ser_t   s, n;
   logic        lrst_s1, lrst;       // reset synchroniser
   logic        sd_q, ws_q;          // falling-edge pin stage
   logic        ws_now, edge_w, en, left_n;
   logic [5:0]  k, nx, dly, res, len, off;
   logic [15:0] samp;

   // bits per word from the resolution field
   function automatic logic [5:0] res_bits(input logic [15:0] c);
      case (c[CFG_RES_LO+:2])
         RES_20:  res_bits = 6'd20;
         RES_24:  res_bits = 6'd24;
         default: res_bits = 6'd16;
      endcase
   endfunction

   // left-align the low res bits into 24
   function automatic logic [23:0] align(input logic [23:0] v, input logic [5:0] r);
      case (r)
         6'd20:   align = {v[19:0], 4'h0};
         6'd24:   align = v;
         default: align = {v[15:0], 8'h00};
      endcase
   endfunction

   // bring core reset into link domain
   always_ff @(posedge link_sck_i) begin
      lrst_s1 <= x.rst;
      lrst    <= lrst_s1;
   end

   // next state of the engine
   always_comb begin
      n = s;
      n.req_s1 = x.req;
      n.req_s2 = s.req_s1;
      if (s.req_s2 != s.seen) begin  // fresh shadow, stable until ack
         n.seen = s.req_s2;
         n.cfg  = x.sh_cfg;
         n.txl  = x.sh_txl;
         n.txr  = x.sh_txr;
         n.mst  = x.sh_mst;
      end
      ws_now = s.mst ? s.ws_gen : x.ws_in;
      edge_w = ws_now != s.ws_prev;
      n.ws_prev = ws_now;
      k = edge_w ? 6'd0 : 6'(s.cnt + 6'd1);
      n.cnt = k;
      dly = s.cfg[CFG_DELAY] ? 6'd1 : 6'd0;
      res = res_bits(s.cfg);
      // right framing shifts every bit, left only its word
      en = s.cfg[CFG_JUSTIFY] || (k >= dly && k < 6'(dly + res));
      if (edge_w) begin
         n.last_len = 6'(s.cnt + 6'd1);
         if (s.ws_prev ^ s.cfg[CFG_POL]) begin
            n.lcap = align(s.sh, res);
         end else begin
            n.rcap   = align(s.sh, res);
            n.rx_tgl = ~s.rx_tgl;
         end
         n.sh = en ? {23'h0, x.sd_in} : 24'h0;
      end else if (en) begin
         n.sh = {s.sh[22:0], x.sd_in};
      end
      if (s.mst && k == 6'(HALF_BITS - 1)) begin  // master word select
         n.ws_gen = ~s.ws_gen;
      end
      // bit for the coming period
      len    = s.mst ? 6'(HALF_BITS) : s.last_len;
      nx     = (6'(k + 6'd1) == len) ? 6'd0 : 6'(k + 6'd1);
      left_n = (nx == 6'd0) ? ~(ws_now ^ s.cfg[CFG_POL]) : (ws_now ^ s.cfg[CFG_POL]);
      samp   = left_n ? s.txl : s.txr;
      off    = s.cfg[CFG_JUSTIFY] ? 6'(len - 6'd1 - nx) : 6'(nx - dly);
      n.nbit = 1'b0;  // at most 16 bits sent
      if (s.cfg[CFG_JUSTIFY]) begin
         if (nx < len && off < 6'd16) n.nbit = samp[off[3:0]];
      end else if (nx >= dly && off < 6'd16) begin
         n.nbit = samp[4'(15 - off[3:0])];
      end
   end

   // state register
   always_ff @(posedge link_sck_i) begin
      if (lrst) begin
         s          <= '0;
         s.last_len <= 6'(HALF_BITS);
      end else begin
         s <= n;
      end
   end

   // data and word select change on falling edge
   always_ff @(negedge link_sck_i) begin
      if (lrst) begin
         sd_q <= 1'b0;
         ws_q <= 1'b0;
      end else begin
         sd_q <= s.nbit;
         ws_q <= s.ws_gen;
      end
   end

   assign x.ack    = s.seen;
   assign x.rx_tgl = s.rx_tgl;
   assign x.rx_l   = s.lcap;
   assign x.rx_r   = s.rcap;
   assign x.sd_out = sd_q;
   assign x.ws_out = ws_q;
endmodule
`default_nettype wire

// File: dasp_top.sv
// digital audio serial port: registers, crossing, pin sharing
`timescale 1ns/1ps
`default_nettype none
module dasp_top #(
   parameter int HALF_BITS = 32
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        link_sck_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        pin_sd_in_i,
   input  wire logic        pin_ws_i,
   output logic             pin_sd_out_o,
   output logic             pin_sd_out_oe_o,
   output logic             pin_sck_o,
   output logic             pin_sck_oe_o,
   output logic             pin_ws_o,
   output logic             pin_ws_oe_o,
   input  wire logic        pcm_out_i,
   input  wire logic        pcm_out_oe_i,
   input  wire logic        pcm_clk_i,
   input  wire logic        pcm_clk_oe_i,
   input  wire logic        pcm_sync_i,
   input  wire logic        pcm_sync_oe_i
);
   import dasp_pkg::*;

   // all register-side state
   typedef struct packed {
      logic [15:0] cfg;      // config word
      logic        own;      // audio owns shared pins
      logic        mst;      // master mode
      logic [7:0]  div;      // bit clock half period
      logic [15:0] txl;      // left sample to send
      logic [15:0] txr;      // right sample to send
      logic [15:0] rxl;      // last left sample
      logic [15:0] rxr;      // last right sample
      logic        fresh;    // pair waiting
      logic        ovr;      // pair lost
      logic        ack;      // bus acknowledge
      logic [31:0] dat;      // bus read data
      logic        req;      // shadow toggle
      logic [15:0] sh_cfg;   // shadow config
      logic [15:0] sh_txl;   // shadow left
      logic [15:0] sh_txr;   // shadow right
      logic        sh_mst;   // shadow master
      logic        ack_s1;   // ack sync first
      logic        ack_s2;   // ack sync second
      logic        rxt_s1;   // pair sync first
      logic        rxt_s2;   // pair sync second
      logic        rxt_seen; // last pair handled
      logic [7:0]  divcnt;   // divider count
      logic        sck;      // generated bit clock
   } dasp_core_t;

   dasp_core_t  s, n;
   logic        hit;       // new bus cycle
   logic        wr;        // write this cycle
   logic        rd;        // read this cycle
   logic [7:0]  word_ofs;  // word-aligned offset
   logic [7:0]  half;      // effective half period
   logic [31:0] rdata;     // read mux

   dasp_xfer_if x ();

   // round right by sh with saturation to 16 bits
   function automatic logic [15:0] round_sat(input logic [23:0] v, input int unsigned sh);
      logic signed [25:0] t;
      t = $signed({{2{v[23]}}, v});
      t = t + (26'sd1 <<< (sh - 1));
      t = t >>> sh;
      if (t > 26'sd32767) begin
         round_sat = 16'h7FFF;
      end else if (t < -26'sd32768) begin
         round_sat = 16'h8000;
      end else begin
         round_sat = t[15:0];
      end
   endfunction

   // 24-bit received word to 16-bit sample
   function automatic logic [15:0] shape(input logic [23:0] v, input logic [15:0] c);
      if (c[CFG_CROP]) begin
         shape = v[23:8];  // keep top bits
      end else if (c[CFG_ATT_EN]) begin
         shape = round_sat(v, ROUND_SH + int'(c[CFG_ATT_LO+:4]));  // one bit per 6 dB
      end else begin
         shape = round_sat(v, ROUND_SH);  // 24 to 16
      end
   endfunction

   // writes honour byte lanes
   function automatic logic [15:0] lanes(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      lanes = old;
      if (sel[0]) lanes[7:0] = d[7:0];
      if (sel[1]) lanes[15:8] = d[15:8];
   endfunction

   // link-side engine
   dasp_serial #(
      .HALF_BITS (HALF_BITS)
   ) u_serial (
      .link_sck_i (link_sck_i),
      .x          (x)
   );

   // what goes to the link side
   assign x.rst    = rst_i;
   assign x.req    = s.req;
   assign x.sh_cfg = s.sh_cfg;
   assign x.sh_txl = s.sh_txl;
   assign x.sh_txr = s.sh_txr;
   assign x.sh_mst = s.sh_mst;
   assign x.sd_in  = pin_sd_in_i;
   assign x.ws_in  = pin_ws_i;

   // bus decode
   assign hit      = wb_cyc_i && wb_stb_i && !s.ack;
   assign wr       = hit && wb_we_i;
   assign rd       = hit && !wb_we_i;
   assign word_ofs = {wb_adr_i[7:2], 2'b00};
   assign half     = (s.div < DIV_RESET) ? DIV_RESET : s.div;

   // read data mux, unmapped reads zero
   always_comb begin
      rdata = 32'h0000_0000;
      case (word_ofs)
         OFS_CONFIG:   rdata[15:0] = s.cfg;
         OFS_CONTROL: begin
            rdata[CTL_OWN]         = s.own;
            rdata[CTL_MASTER]      = s.mst;
            rdata[CTL_DIV_LO+:8]   = s.div;
         end
         OFS_TX_LEFT:  rdata[15:0] = s.txl;
         OFS_TX_RIGHT: rdata[15:0] = s.txr;
         OFS_RX_LEFT:  rdata[15:0] = s.rxl;
         OFS_RX_RIGHT: rdata[15:0] = s.rxr;
         OFS_STATUS: begin
            rdata[STS_FRESH] = s.fresh;
            rdata[STS_OVR]   = s.ovr;
         end
         default:      rdata = 32'h0000_0000;
      endcase
   end

   // next state
   always_comb begin
      n = s;
      // one-wait-state slave, ack drops after one cycle
      n.ack = hit;
      if (rd) begin
         n.dat = rdata;
      end
      if (wr) begin
         case (word_ofs)
            OFS_CONFIG:   n.cfg = lanes(s.cfg, wb_dat_i, wb_sel_i) & CFG_MASK;
            OFS_CONTROL: begin
               if (wb_sel_i[0]) begin
                  n.own = wb_dat_i[CTL_OWN];
                  n.mst = wb_dat_i[CTL_MASTER];
               end
               if (wb_sel_i[1]) begin
                  n.div = wb_dat_i[CTL_DIV_LO+:8];
               end
            end
            OFS_TX_LEFT:  n.txl = lanes(s.txl, wb_dat_i, wb_sel_i);
            OFS_TX_RIGHT: n.txr = lanes(s.txr, wb_dat_i, wb_sel_i);
            OFS_STATUS: begin
               if (wb_sel_i[0] && wb_dat_i[STS_OVR]) begin
                  n.ovr = 1'b0;  // write one clears
               end
            end
            default: begin
               n.ovr = s.ovr;  // unmapped write ignored
            end
         endcase
      end
      // reading right sample consumes the pair
      if (rd && word_ofs == OFS_RX_RIGHT) begin
         n.fresh = 1'b0;
      end
      // shadow handshake, refreshed whenever idle
      n.ack_s1 = x.ack;
      n.ack_s2 = s.ack_s1;
      if (s.ack_s2 == s.req) begin
         n.sh_cfg = s.cfg;
         n.sh_txl = s.txl;
         n.sh_txr = s.txr;
         n.sh_mst = s.own && s.mst;
         n.req    = ~s.req;
      end
      // received pair arrives, set beats clear
      n.rxt_s1 = x.rx_tgl;
      n.rxt_s2 = s.rxt_s1;
      if (s.rxt_s2 != s.rxt_seen) begin
         n.rxt_seen = s.rxt_s2;
         n.rxl      = shape(x.rx_l, s.cfg);
         n.rxr      = shape(x.rx_r, s.cfg);
         n.fresh    = 1'b1;
         if (s.fresh) begin
            n.ovr = 1'b1;
         end
      end
      // bit clock divider for master mode
      if (s.own && s.mst) begin
         if (8'(s.divcnt + 8'd1) >= half) begin
            n.divcnt = 8'h00;
            n.sck    = ~s.sck;
         end else begin
            n.divcnt = 8'(s.divcnt + 8'd1);
         end
      end else begin
         n.divcnt = 8'h00;
         n.sck    = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s     <= '0;
         s.cfg <= CFG_RESET;
         s.div <= DIV_RESET;
      end else begin
         s <= n;
      end
   end

   // bus outputs
   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.dat;

   // shared pins go to exactly one owner
   assign pin_sd_out_o    = s.own ? x.sd_out : pcm_out_i;
   assign pin_sd_out_oe_o = s.own ? 1'b1 : pcm_out_oe_i;
   assign pin_sck_o       = s.own ? s.sck : pcm_clk_i;
   assign pin_sck_oe_o    = s.own ? s.mst : pcm_clk_oe_i;
   assign pin_ws_o        = s.own ? x.ws_out : pcm_sync_i;
   assign pin_ws_oe_o     = s.own ? s.mst : pcm_sync_oe_i;
endmodule
`default_nettype wire

// File: dasp_top_checker.sv
// port assertions for the digital audio serial port
`timescale 1ns/1ps
`default_nettype none
module dasp_top_checker (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        link_sck_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic        pin_sd_out_o,
   input wire logic        pin_sd_out_oe_o,
   input wire logic        pin_sck_o,
   input wire logic        pin_sck_oe_o,
   input wire logic        pin_ws_o,
   input wire logic        pin_ws_oe_o,
   input wire logic        pcm_out_i,
   input wire logic        pcm_out_oe_i,
   input wire logic        pcm_clk_i,
   input wire logic        pcm_clk_oe_i,
   input wire logic        pcm_sync_i,
   input wire logic        pcm_sync_oe_i
);
   logic [7:0] sck_age;  // core cycles since the bit clock pin moved
   logic       hi_sd;    // data pin at the last link rising edge
   logic       hi_own;   // audio owned the data pin at that edge
   // age of the bit clock level, saturating
   always_ff @(posedge clk_i) begin
      if (rst_i) sck_age <= 8'hff;
      else if ($changed(pin_sck_o)) sck_age <= 8'h00;
      else if (sck_age != 8'hff) sck_age <= sck_age + 8'h01;
   end
   // data pin level seen while the link clock is high
   always_ff @(posedge link_sck_i) begin
      hi_sd  <= pin_sd_out_o;
      hi_own <= pin_sd_out_oe_o & ~pcm_out_oe_i;
   end
   chk_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack one cycle after request");
   chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   chk_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   chk_rdata_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i)) else $error("read data moved outside a read");
   chk_reset_quiet: assert property (@(posedge clk_i)
      rst_i |=> !wb_ack_o && wb_dat_o == 32'h0000_0000) else $error("bus not idle in reset");
   // clock enable without the voice enable means the audio side drives it
   chk_master_owns: assert property (@(posedge clk_i) disable iff (rst_i)
      pin_sck_oe_o && !pcm_clk_oe_i |-> pin_sd_out_oe_o && pin_ws_oe_o)
      else $error("clock driven without owning pins");
   chk_voice_pass: assert property (@(posedge clk_i) disable iff (rst_i)
      !pin_sd_out_oe_o |-> pin_sck_oe_o == pcm_clk_oe_i && pin_ws_oe_o == pcm_sync_oe_i
      && pin_sck_o == pcm_clk_i && pin_ws_o == pcm_sync_i && pin_sd_out_o == pcm_out_i)
      else $error("voice port not on pins");
   chk_sck_half: assert property (@(posedge clk_i) disable iff (rst_i)
      pin_sck_oe_o && !pcm_clk_oe_i && $changed(pin_sck_o) |-> sck_age >= 8'd15)
      else $error("bit clock phase too short");
   chk_sd_fall: assert property (@(negedge link_sck_i) disable iff (rst_i)
      hi_own && pin_sd_out_oe_o && !pcm_out_oe_i |-> pin_sd_out_o == hi_sd) else $error("data moved on rising");
endmodule
bind dasp_top dasp_top_checker i_chk (.*);
`default_nettype wire

// File: dasp_codec_model.sv
// far-side codec: makes bit clock, word select and data, captures output
`timescale 1ns/1ps
`default_nettype none
module dasp_codec_model #(
   parameter int HB = 32
) (
   output logic      sck_o,
   output logic      ws_o,
   output logic      sd_o,
   input  wire logic sd_out_i
);
   logic [15:0] cfg = 16'h0000;      // framing chosen by the bench
   logic [23:0] word [2] = '{0, 0};  // raw samples, index 0 left
   logic [31:0] got  [2];            // captured halves, first bit on top
   logic [31:0] sh;                  // capture shift register
   initial begin
      sck_o = 1'b0;
      ws_o = 1'b0;
      sd_o = 1'b0;
   end
   // one bit period: data set while clock low, both sides sample on rise
   task automatic bit_slot(input logic v);
      sd_o = v;
      #24 sck_o = 1'b1;
      sh = {sh[30:0], sd_out_i};
      #24 sck_o = 1'b0;
   endtask
   // whole frames, then a closing word select edge; clock idles low after
   task automatic run(input int frames);
      int res;
      int k;
      res = (cfg[9:8] == 2'h2) ? 24 : (cfg[9:8] == 2'h1) ? 20 : 16;
      for (int f = 0; f < frames; f++) begin
         for (int h = 0; h < 2; h++) begin
            ws_o = cfg[2] ^ h[0] ^ 1'b1;
            for (int i = 0; i < HB; i++) begin
               k = cfg[0] ? i - (HB - res) : i - int'(cfg[1]);
               bit_slot((k >= 0 && k < res) ? word[h][23 - k] : ~sd_o);
            end
            got[h] = sh;
         end
      end
      ws_o = ~cfg[2];
      repeat (6) bit_slot(~sd_o);
   endtask
endmodule
`default_nettype wire

// File: dasp_tb_top.sv
// self-checking bench for the audio serial port in slave and master mode
`timescale 1ns/1ps
`default_nettype none
module dasp_tb_top;
   import dasp_pkg::*;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, seed, rd;
   logic        pin_sd_out_o, pin_sd_out_oe_o, pin_sck_o, pin_sck_oe_o, pin_ws_o, pin_ws_oe_o;
   logic        pcm_out_i, pcm_out_oe_i, pcm_clk_i, pcm_clk_oe_i, pcm_sync_i, pcm_sync_oe_i;
   wire         link_sck_i, codec_sck, pin_ws_i, pin_sd_in_i;  // from the codec model, link clock from the bit clock pin in master mode
   logic        loop_sck = 1'b0;                   // master: bit clock pin fed back
   logic        ws_was;                            // word select level before a wait
   int          cyc;                               // core cycles between word select edges
   int          fails, compares;
   logic [15:0] txs [2];                             // samples to send
   logic [23:0] msk;                                 // bits kept by resolution
   logic [15:0] cfgs [7] = '{16'h0206, 16'h0606, 16'h022E, 16'h0201, 16'h0001, 16'h0406, 16'h0312};
   dasp_top #(.HALF_BITS(32)) i_dut (.*);
   dasp_codec_model #(.HB(32)) i_codec (.sck_o(codec_sck), .ws_o(pin_ws_i), .sd_o(pin_sd_in_i),
                                        .sd_out_i(pin_sd_out_o));
   // link clock from the codec, or the design's own bit clock in master mode
   assign link_sck_i = loop_sck ? pin_sck_o : codec_sck;
   // core clock, 5 ns
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // xorshift source
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // voice port inputs wander at random
   always @(posedge clk_i) {pcm_out_i, pcm_out_oe_i, pcm_clk_i, pcm_clk_oe_i, pcm_sync_i, pcm_sync_oe_i} <= 6'(xs());
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         fails++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic test_done();
      if (fails == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // one classic bus cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 64);
      rd = wb_dat_o;
      if (n >= 64) fails++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // expected 16-bit sample from a raw word
   function automatic logic [31:0] shape(input logic [23:0] raw, input logic [15:0] c);
      int v;
      int s;
      v = $signed({{8{raw[23]}}, raw});
      if (c[10]) return {16'h0000, raw[23:8]};
      s = 8 + (c[3] ? int'(c[7:4]) : 0);
      v = (v + (1 <<< (s - 1))) >>> s;
      if (v > 32767) v = 32767;
      if (v < -32768) v = -32768;
      return {16'h0000, v[15:0]};
   endfunction
   // watchdog: the tests need about 21k core cycles, this allows 60k
   initial begin
      #300_000;
      fails++;
      test_done();
   end
   // main sequence
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {4'h8, 8'h00, 32'h0, 4'h3};
      {pcm_out_i, pcm_out_oe_i, pcm_clk_i, pcm_clk_oe_i, pcm_sync_i, pcm_sync_oe_i} = 6'h00;
      seed = 32'hbd07;
      fails = 0;
      compares = 0;
      i_codec.run(0);
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, OFS_CONFIG, 32'h0);
      check(rd, 32'(CFG_RESET));
      wb(1'b1, OFS_CONFIG, 32'hffff_ffff);
      wb(1'b0, OFS_CONFIG, 32'h0);
      check(rd, 32'(CFG_MASK));
      wb(1'b0, 8'h1c, 32'h0);
      check(rd, 32'h0000_0000);
      wb(1'b1, OFS_CONTROL, 32'h0000_1001);
      check({29'h0, pin_sd_out_oe_o, pin_sck_oe_o, pin_ws_oe_o}, 32'h4);
      foreach (cfgs[j]) begin
         i_codec.cfg = cfgs[j];
         for (int h = 0; h < 2; h++) begin
            i_codec.word[h] = (j == 0 && h == 0) ? 24'h7f_ffff : 24'(xs());
            txs[h] = 16'(xs());
         end
         msk = (cfgs[j][9:8] == 2'h2) ? 24'hff_ffff : (cfgs[j][9:8] == 2'h1) ? 24'hff_fff0 : 24'hff_ff00;
         wb(1'b1, OFS_CONFIG, {16'h0000, cfgs[j]});
         wb(1'b1, OFS_TX_LEFT, {16'h0000, txs[0]});
         wb(1'b1, OFS_TX_RIGHT, {16'h0000, txs[1]});
         i_codec.run(4);
         wb(1'b0, OFS_STATUS, 32'h0);
         check({30'h0, rd[1:0]}, 32'h3);
         wb(1'b0, OFS_RX_LEFT, 32'h0);
         check(rd, shape(i_codec.word[0] & msk, cfgs[j]));
         wb(1'b0, OFS_RX_RIGHT, 32'h0);
         check(rd, shape(i_codec.word[1] & msk, cfgs[j]));
         wb(1'b1, OFS_STATUS, 32'h0000_0002);
         wb(1'b0, OFS_STATUS, 32'h0);
         check(rd, 32'h0000_0000);
         for (int h = 0; h < 2; h++) begin
            if (cfgs[j][0]) check(i_codec.got[h], {16'h0000, txs[h]});
            else check(i_codec.got[h] << cfgs[j][1], {txs[h], 16'h0000});
         end
      end
      // master mode, half period asked below the floor
      loop_sck <= 1'b1;
      wb(1'b1, OFS_CONTROL, 32'h0000_0503);
      check({29'h0, pin_sd_out_oe_o, pin_sck_oe_o, pin_ws_oe_o}, 32'h7);
      for (int e = 0; e < 3; e++) begin
         cyc = 0;
         ws_was = pin_ws_o;
         while (pin_ws_o === ws_was && cyc < 4000) begin
            @(negedge clk_i);
            cyc++;
         end
         if (e > 0) check(32'(cyc), 32'(2 * 32 * DIV_RESET));
      end
      @(posedge clk_i);
      test_done();
   end
endmodule
`default_nettype wire
